// File: hdl/isfl_cfg.svh
// Constants for the I2C status flag logic
`ifndef ISFL_CFG_SVH
`define ISFL_CFG_SVH
`define ISFL_ADDR_W      4
`define ISFL_OFF_CTRL    4'h0
`define ISFL_OFF_STAT    4'h1
`define ISFL_OFF_IMASK   4'h2
`define ISFL_OFF_DATA    4'h3
`define ISFL_BIT_AL      0
`define ISFL_BIT_IFACE_IRQ_FLAG    1
`define ISFL_BIT_BUSY    2
`define ISFL_BIT_PROH    3
`define ISFL_BIT_MST     0
`define ISFL_BIT_TX      1
`define ISFL_BIT_FMT     2
`define ISFL_RST_CTRL    8'h00
`define ISFL_RST_MASK    8'h00
`endif

// File: hdl/isfl_pkg.sv
// Types for the I2C status flag logic
package isfl_pkg;
  // Events from the shift and address path
  typedef struct packed {
    logic xfer_end;   // Byte transfer finished
    logic addr_match; // Own slave address matched
    logic gen_call;   // General call detected
    logic rstart;     // Repeated start detected
    logic stop;       // Stop detected
  } isfl_evt_t;
  // Slave follow state
  typedef enum logic [0:0] {
    ISFL_IDLE = 1'b0,
    ISFL_ADDR = 1'b1
  } isfl_slv_t;
endpackage

// File: hdl/isfl_top.sv
// Status and control flags of an I2C bus interface
`timescale 1ns/10ps
`include "isfl_cfg.svh"
module isfl_top (
  input  wire logic                    sys_clk,
  input  wire logic                    rst_n,
  input  wire logic [`ISFL_ADDR_W-1:0] addr,
  input  wire logic [7:0]              wdata,
  input  wire logic                    wr_stb,
  input  wire logic                    rd_stb,
  output logic      [7:0]              rdata,
  input  wire logic                    scl_in,
  input  wire logic                    sda_in,
  input  wire logic                    int_sda,
  input  wire logic                    int_scl,
  input  wire isfl_pkg::isfl_evt_t     evt,
  output logic                         start_req,
  output logic                         stop_req,
  output logic                         irq
);
  // Two-stage synchronisers for the bus pins
  logic [1:0] scl_s_q, scl_s_d;
  logic [1:0] sda_s_q, sda_s_d;
  logic       scl_p_q, scl_p_d;   // Previous synced SCL
  // Software state
  logic [7:0] ctrl_q, ctrl_d;     // Mode bits
  logic [7:0] mask_q, mask_d;     // Interrupt mask
  logic       busy_q, busy_d;     // Bus busy bit
  logic       al_q, al_d;         // Arbitration lost flag
  logic       iface_irq_flag_q, iface_irq_flag_d;     // Interface irq flag
  logic       al_seen_q, al_seen_d;   // Read as one armed
  logic       iface_irq_flag_seen_q, iface_irq_flag_seen_d;
  isfl_pkg::isfl_slv_t slv_q, slv_d;  // Slave follow state
  logic [7:0] rdata_d;
  logic       start_d, stop_d, irq_d;
  logic       scl_rise, scl_fall, mst, tx, al_set, iface_irq_flag_set;
  logic       wr_stat, wr_ctrl, wr_mask, rd_stat, dat_acc;

  // Match a decoded register access
  function automatic logic hit(input logic stb,
                               input logic [`ISFL_ADDR_W-1:0] a,
                               input logic [`ISFL_ADDR_W-1:0] o);
    hit = stb && (a == o);
  endfunction

  // Next-state logic
  always_comb begin
    scl_s_d  = {scl_s_q[0], scl_in};
    sda_s_d  = {sda_s_q[0], sda_in};
    scl_p_d  = scl_s_q[1];
    scl_rise = scl_s_q[1] && !scl_p_q;
    scl_fall = !scl_s_q[1] && scl_p_q;
    mst      = ctrl_q[`ISFL_BIT_MST];
    tx       = ctrl_q[`ISFL_BIT_TX];
    wr_stat  = hit(wr_stb, addr, `ISFL_OFF_STAT);
    wr_ctrl  = hit(wr_stb, addr, `ISFL_OFF_CTRL);
    wr_mask  = hit(wr_stb, addr, `ISFL_OFF_IMASK);
    rd_stat  = hit(rd_stb, addr, `ISFL_OFF_STAT);
    // Data write in transmit, read in receive
    dat_acc  = tx ? hit(wr_stb, addr, `ISFL_OFF_DATA)
                  : hit(rd_stb, addr, `ISFL_OFF_DATA);
    // Arbitration loss in master transmit
    al_set = mst && tx &&
             ((scl_rise && (int_sda != sda_s_q[1])) ||
              (scl_fall && int_scl));
    // Slave follow state machine
    slv_d = slv_q;
    case (slv_q)
      isfl_pkg::ISFL_IDLE: begin
        if (!mst && !ctrl_q[`ISFL_BIT_FMT] &&
            (evt.addr_match || evt.gen_call)) begin
          slv_d = isfl_pkg::ISFL_ADDR;
        end
      end
      isfl_pkg::ISFL_ADDR: begin
        if (mst || evt.rstart || evt.stop) begin
          slv_d = isfl_pkg::ISFL_IDLE;
        end
      end
      default: slv_d = isfl_pkg::ISFL_IDLE;
    endcase
    // Interrupt flag sources
    iface_irq_flag_set = (mst && (evt.xfer_end || al_set)) ||
               (!mst && !ctrl_q[`ISFL_BIT_FMT] &&
                (evt.addr_match ||
                 evt.gen_call ||
                 (slv_q == isfl_pkg::ISFL_ADDR &&
                  evt.xfer_end)));
    // Read-as-one arming for the clear sequence
    al_seen_d   = al_seen_q;
    iface_irq_flag_seen_d = iface_irq_flag_seen_q;
    if (rd_stat) begin
      al_seen_d   = al_q;
      iface_irq_flag_seen_d = iface_irq_flag_q;
    end
    // Arbitration lost flag; set beats clear
    al_d = al_q;
    if (dat_acc) begin
      al_d = 1'b0;
    end
    if (wr_stat && !wdata[`ISFL_BIT_AL] && al_seen_q) begin
      al_d = 1'b0;
    end
    if (al_set) begin
      al_d = 1'b1;
    end
    // Interface irq flag; set beats clear
    iface_irq_flag_d = iface_irq_flag_q;
    if (wr_stat && !wdata[`ISFL_BIT_IFACE_IRQ_FLAG] && iface_irq_flag_seen_q) begin
      iface_irq_flag_d = 1'b0;
    end
    if (iface_irq_flag_set) begin
      iface_irq_flag_d = 1'b1;
    end
    if (wr_stat) begin
      al_seen_d   = 1'b0;
      iface_irq_flag_seen_d = 1'b0;
    end
    // Start or stop request; writes of one ignored
    busy_d  = busy_q;
    start_d = 1'b0;
    stop_d  = 1'b0;
    if (wr_stat && !wdata[`ISFL_BIT_PROH]) begin
      busy_d  = wdata[`ISFL_BIT_BUSY];
      start_d = wdata[`ISFL_BIT_BUSY];
      stop_d  = !wdata[`ISFL_BIT_BUSY];
    end
    ctrl_d = wr_ctrl ? wdata : ctrl_q;
    mask_d = wr_mask ? wdata : mask_q;
    irq_d  = (al_d && mask_q[`ISFL_BIT_AL]) ||
             (iface_irq_flag_d && mask_q[`ISFL_BIT_IFACE_IRQ_FLAG]);
    // Read mux, prohibit bit always one
    rdata_d = 8'h00;
    if (rd_stb) begin
      case (addr)
        `ISFL_OFF_CTRL:  rdata_d = ctrl_q;
        `ISFL_OFF_IMASK: rdata_d = mask_q;
        `ISFL_OFF_STAT: begin
          rdata_d[`ISFL_BIT_AL]   = al_q;
          rdata_d[`ISFL_BIT_IFACE_IRQ_FLAG] = iface_irq_flag_q;
          rdata_d[`ISFL_BIT_BUSY] = busy_q;
          rdata_d[`ISFL_BIT_PROH] = 1'b1;
        end
        default: rdata_d = 8'h00;
      endcase
    end
  end

  // Register stage
  always_ff @(posedge sys_clk) begin
    if (!rst_n) begin
      scl_s_q     <= 2'h3;
      sda_s_q     <= 2'h3;
      scl_p_q     <= 1'b1;
      ctrl_q      <= `ISFL_RST_CTRL;
      mask_q      <= `ISFL_RST_MASK;
      busy_q      <= 1'b0;
      al_q        <= 1'b0;
      iface_irq_flag_q      <= 1'b0;
      al_seen_q   <= 1'b0;
      iface_irq_flag_seen_q <= 1'b0;
      slv_q       <= isfl_pkg::ISFL_IDLE;
      rdata       <= 8'h00;
      start_req   <= 1'b0;
      stop_req    <= 1'b0;
      irq         <= 1'b0;
    end else begin
      scl_s_q     <= scl_s_d;
      sda_s_q     <= sda_s_d;
      scl_p_q     <= scl_p_d;
      ctrl_q      <= ctrl_d;
      mask_q      <= mask_d;
      busy_q      <= busy_d;
      al_q        <= al_d;
      iface_irq_flag_q      <= iface_irq_flag_d;
      al_seen_q   <= al_seen_d;
      iface_irq_flag_seen_q <= iface_irq_flag_seen_d;
      slv_q       <= slv_d;
      rdata       <= rdata_d;
      start_req   <= start_d;
      stop_req    <= stop_d;
      irq         <= irq_d;
    end
  end
endmodule

// File: test/isfl_top_properties.sv
// Port checker for the I2C status flag logic
`timescale 1ns/10ps
module isfl_checker (
  input wire logic       sys_clk,
  input wire logic       rst_n,
  input wire logic [3:0] addr,
  input wire logic [7:0] wdata,
  input wire logic       wr_stb,
  input wire logic       rd_stb,
  input wire logic [7:0] rdata,
  input wire logic       start_req,
  input wire logic       stop_req
);
  default clocking @(posedge sys_clk); endclocking
  default disable iff (!rst_n);
  // Status register write in this cycle
  wire logic sw = wr_stb && addr == 4'h1;
  property p_start; sw && !wdata[3] && wdata[2] |=> start_req; endproperty
  a_start: assert property (p_start) else $error("no start");
  property p_stop; sw && !wdata[3] && !wdata[2] |=> stop_req; endproperty
  a_stop: assert property (p_stop) else $error("no stop");
  property p_ign; sw && wdata[3] |=> !start_req && !stop_req; endproperty
  a_ign: assert property (p_ign) else $error("one not ignored");
  property p_proh; rd_stb && addr == 4'h1 |=> rdata[3]; endproperty
  a_proh: assert property (p_proh) else $error("prohibit read 0");
  property p_spon; !sw |=> !start_req && !stop_req; endproperty
  a_spon: assert property (p_spon) else $error("request unasked");
  property p_unm; rd_stb && addr > 4'h3 |=> rdata == 8'h00; endproperty
  a_unm: assert property (p_unm) else $error("unmapped read");
  property p_idle; !rd_stb |=> rdata == 8'h00; endproperty
  a_idle: assert property (p_idle) else $error("rdata not idle");
  property p_rsv; rd_stb && addr == 4'h1 |=> rdata[7:4] == 4'h0; endproperty
  a_rsv: assert property (p_rsv) else $error("reserved bits set");
endmodule
bind isfl_top isfl_checker u_chk (.sys_clk(sys_clk), .rst_n(rst_n),
  .addr(addr), .wdata(wdata), .wr_stb(wr_stb), .rd_stb(rd_stb),
  .rdata(rdata), .start_req(start_req), .stop_req(stop_req));

// File: test/isfl_bus_peer.sv
// Other bus device: frame clock and wired-and data
`timescale 1ns/10ps
module isfl_bus_peer (
  input  wire logic run,
  input  wire logic pull,
  input  wire logic int_sda,
  output logic      scl,
  output logic      sda
);
  initial scl = 1'b1;
  // Clock toggles only within a frame, pull-up high otherwise
  always #62.5 scl = run ? ~scl : 1'b1;
  // Open drain: low when either party pulls
  assign sda = int_sda & ~pull;
endmodule

// File: test/tb_top.sv
// Testbench for the I2C status flag logic
`timescale 1ns/10ps
module tb_top;
  logic sys_clk = 1'b0, rst_n = 1'b0, wr_stb = 1'b0, rd_stb = 1'b0;
  logic [3:0] addr = 4'h0;
  logic [7:0] wdata = 8'h00, rdata;
  logic start_req, stop_req, irq, scl, sda;
  logic run = 1'b0, pull = 1'b0, int_sda = 1'b1, hold = 1'b0;
  isfl_pkg::isfl_evt_t evt = '0;
  int fails = 0, comparisons = 0, cyc = 0;
  always #2.5 sys_clk = ~sys_clk;
  isfl_bus_peer u_peer (.run(run), .pull(pull), .int_sda(int_sda),
    .scl(scl), .sda(sda));
  isfl_top u_dut (.sys_clk(sys_clk), .rst_n(rst_n), .addr(addr),
    .wdata(wdata), .wr_stb(wr_stb), .rd_stb(rd_stb), .rdata(rdata),
    .scl_in(scl), .sda_in(sda), .int_sda(int_sda), .int_scl(scl | hold),
    .evt(evt), .start_req(start_req), .stop_req(stop_req), .irq(irq));
  task automatic cmp(input logic [7:0] got, input logic [7:0] exp);
    comparisons++;
    if (got !== exp) begin
      fails++;
      $display("CHECK FAILED t=%0t got %h exp %h", $time, got, exp);
    end
  endtask
  task automatic wr(input logic [3:0] a, input logic [7:0] d);
    @(posedge sys_clk);
    addr <= a;
    wdata <= d;
    wr_stb <= 1'b1;
    @(posedge sys_clk);
    wr_stb <= 1'b0;
  endtask
  // Register read, busy bit left out
  task automatic rd(input logic [3:0] a, input logic [7:0] e);
    @(posedge sys_clk);
    addr <= a;
    rd_stb <= 1'b1;
    @(posedge sys_clk);
    rd_stb <= 1'b0;
    #1 cmp(rdata & 8'hfb, e);
  endtask
  task automatic frame(input logic p, input logic h);
    @(posedge sys_clk);
    pull <= p;
    hold <= h;
    run <= 1'b1;
    repeat (60) @(posedge sys_clk);
    run <= 1'b0;
    repeat (40) @(posedge sys_clk);
    pull <= 1'b0;
    hold <= 1'b0;
  endtask
  task automatic ev(input logic [4:0] v);
    @(posedge sys_clk);
    evt <= v;
    @(posedge sys_clk);
    evt <= '0;
    repeat (4) @(posedge sys_clk);
  endtask
  task automatic t_cmd;
    rd(4'h1, 8'h08);
    wr(4'h1, 8'h04);
    #1 cmp({6'h0, start_req, stop_req}, 8'h02);
    wr(4'h1, 8'h00);
    #1 cmp({6'h0, start_req, stop_req}, 8'h01);
    wr(4'h1, 8'h0c);
    #1 cmp({6'h0, start_req, stop_req}, 8'h00);
    rd(4'h9, 8'h00);
  endtask
  task automatic t_arb;
    wr(4'h0, 8'h03);
    wr(4'h2, 8'h03);
    frame(1'b1, 1'b0);
    rd(4'h1, 8'h0b);
    cmp({7'h0, irq}, 8'h01);
    wr(4'h1, 8'h0b);
    wr(4'h1, 8'h08);
    rd(4'h1, 8'h0b);
    wr(4'h1, 8'h08);
    rd(4'h1, 8'h08);
    cmp({7'h0, irq}, 8'h00);
  endtask
  task automatic t_scl;
    frame(1'b0, 1'b1);
    rd(4'h1, 8'h0b);
    wr(4'h3, 8'h5a);
    rd(4'h1, 8'h0a);
    wr(4'h1, 8'h08);
    ev(5'h10);
    rd(4'h1, 8'h0a);
    wr(4'h1, 8'h08);
    // Receive mode: a data register read clears the flag
    frame(1'b0, 1'b1);
    wr(4'h0, 8'h01);
    rd(4'h3, 8'h00);
    rd(4'h1, 8'h0a);
    wr(4'h1, 8'h08);
    rd(4'h1, 8'h08);
  endtask
  // Slave follow: own address then general call
  task automatic t_slv(input logic [4:0] k, input logic [4:0] q);
    wr(4'h0, 8'h00);
    ev(k);
    rd(4'h1, 8'h0a);
    wr(4'h1, 8'h08);
    ev(5'h10);
    rd(4'h1, 8'h0a);
    wr(4'h1, 8'h08);
    ev(q);
    ev(5'h10);
    rd(4'h1, 8'h08);
  endtask
  task automatic complete_run;
    $display("fails=%0d comparisons=%0d", fails, comparisons);
    if (fails == 0 && comparisons > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask
  // Cycle ceiling against a hang
  always @(posedge sys_clk) begin
    cyc++;
    if (cyc == 20000) begin
      fails++;
      complete_run;
    end
  end
  initial begin
    repeat (2) @(posedge sys_clk);
    rst_n <= 1'b1;
    t_cmd;
    t_arb;
    t_scl;
    t_slv(5'h08, 5'h01);
    t_slv(5'h04, 5'h02);
    complete_run;
  end
endmodule
